/* design/lprt_defs.svh */
// Shared timing constants and bit positions for the long-press reset timer.
// Assumes a 100 MHz core clock; included by bare name by the pin synchroniser, tick generator and timer files.
//
// Notes on behaviour
// - Time only while both requests held low.
// - Latching: strap low 7.5 s, high 11.25 s.
// - Latching: hold reset until a request rises.
// - Pulse variants: fixed delay, no strap.
// - Pulse variants: release after release time.
// - Pulse variants: early release when request rises.
// - Release time fixed per delay option.
// - Delay and release within ten percent.
// - Main reset active low, open drain.
// - High output mirrors open-drain reset exactly.
`ifndef LPRT_DEFS_SVH
`define LPRT_DEFS_SVH

// ----------------------------------------
// Clock and tick
// ----------------------------------------
`define LPRT_CLK_HZ        100000000
`define LPRT_TICK_US       1000
`define LPRT_TICK_CYC      ((`LPRT_CLK_HZ / 1000000) * `LPRT_TICK_US)

// ----------------------------------------
// Times in milliseconds, except LPRT_REL_1875_US in microseconds
// ----------------------------------------
`define LPRT_DLY_SHORT_MS  7500
`define LPRT_DLY_LONG_MS   11250
`define LPRT_DLY_10S_MS    10000
`define LPRT_DLY_3S_MS     3000
`define LPRT_REL_234_MS    234
`define LPRT_REL_313_MS    313
`define LPRT_REL_78_MS     78
`define LPRT_REL_1875_US   187500
`define LPRT_MS_TICKS(ms)  ((ms) * 1000 / `LPRT_TICK_US)

// ----------------------------------------
// Request vector bit positions
// ----------------------------------------
`define LPRT_REQ_A         0
`define LPRT_REQ_B         1

// ----------------------------------------
// Pin conditioning
// ----------------------------------------
`define LPRT_SYNC_STAGES   3

`endif

/* design/lprt_pkg.sv */
// Types of the long-press reset timer.
// Assumes nothing beyond the shared defs header.
package lprt_pkg;
    typedef enum logic [1:0]
    {
        LPRT_IDLE,
        LPRT_TIMING,
        LPRT_ASSERT,
        LPRT_WAIT_RISE
    } lprt_state_t;
endpackage

/* design/lprt_sync_if.sv */
// Carrier between the top and its pin synchroniser.
// Assumes one clock domain.
`timescale 1ns/1ps
interface lprt_sync_if;
    logic [1:0] raw;
    logic [1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

/* design/lprt_pin_sync.sv */
// Three-stage pin synchroniser; a change counts when stages two and three
// agree. Assumes asynchronous pins and an active-high asynchronous reset.
`timescale 1ns/1ps
`include "lprt_defs.svh"
module lprt_pin_sync
    import lprt_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    // Clock and reset
    input wire logic  core_clk,
    input wire logic  sys_rst,
    // Pins
    lprt_sync_if.sync pins
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] clean_q;
    logic [WIDTH-1:0] clean_d;

    // Idle pins are high, so reset to high to avoid a false press.
    assign clean_d = (s2_q == s3_q) ? s3_q : clean_q;
    assign pins.clean = clean_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q    <= '1;
            s2_q    <= '1;
            s3_q    <= '1;
            clean_q <= '1;
        end
        else
        begin
            s1_q    <= pins.raw;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            clean_q <= clean_d;
        end
    end

    initial
    begin
        if (WIDTH < 1)
            $error("WIDTH must be at least one.");
    end
endmodule

/* design/lprt_tick_gen.sv */
// Free-running tick generator: a one-cycle tick every TICK_CYC cycles.
// Assumes the core clock is the only clock.
`timescale 1ns/1ps
`include "lprt_defs.svh"
module lprt_tick_gen
    import lprt_pkg::*;
#(
    parameter int TICK_CYC = `LPRT_TICK_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Tick
    output logic     tick
);
    localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    logic [CW-1:0] cnt_q;
    logic          tick_q;
    logic          wrap;

    assign wrap = (cnt_q == CW'(TICK_CYC - 1));
    assign tick = tick_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
            tick_q <= wrap;
        end
    end

    initial
    begin
        if (TICK_CYC < 1)
            $error("TICK_CYC must be at least one.");
    end
endmodule

/* design/lprt_timer.sv */
// Long-press reset timer top. Two active-low key requests must both be low
// for the whole output delay before reset asserts.
// Assumes asynchronous key pins, a strap that is steady after reset, and an
// outside pull-up on the open-drain reset wire.
`timescale 1ns/1ps
`include "lprt_defs.svh"
module lprt_timer
    import lprt_pkg::*;
#(
    parameter bit LATCHING  = 1'b1,
    parameter int TICK_CYC  = `LPRT_TICK_CYC,
    parameter int DLY_LOW   = `LPRT_MS_TICKS(`LPRT_DLY_SHORT_MS),
    parameter int DLY_HIGH  = `LPRT_MS_TICKS(`LPRT_DLY_LONG_MS),
    parameter int DLY_FIXED = `LPRT_MS_TICKS(`LPRT_DLY_SHORT_MS),
    parameter int REL_TICKS = `LPRT_MS_TICKS(`LPRT_REL_234_MS)
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Key requests and strap
    input wire logic key_request_a_n,
    input wire logic key_request_b_n,
    input wire logic delay_select,
    input wire logic factory_pin_a,
    input wire logic factory_pin_b,
    // Reset outputs
    output logic     reset_out_n_o,
    output logic     reset_out_n_oe,
    output logic     reset_out_high
);
    // ----------------------------------------
    // Pin conditioning and time base
    // ----------------------------------------
    // Factory pins are tied low outside and have no function here.
    localparam int TW = 24;

    lprt_sync_if   sif ();
    logic          tick;
    logic          both_low;
    logic          any_high;

    assign sif.raw[`LPRT_REQ_A] = key_request_a_n;
    assign sif.raw[`LPRT_REQ_B] = key_request_b_n;

    lprt_pin_sync #(.WIDTH(2)) u_sync
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pins     (sif.sync)
    );

    lprt_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tick     (tick)
    );

    assign both_low = ~sif.clean[`LPRT_REQ_A] & ~sif.clean[`LPRT_REQ_B];
    assign any_high = ~both_low;

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    // The strap is caught once after reset release, never by the reset.
    logic                         strap_s1_q;
    logic                         strap_s2_q;
    logic                         strap_s3_q;
    logic [`LPRT_SYNC_STAGES-1:0] strap_vld_q;
    logic                         strap_q;
    logic                         strap_done_q;
    logic                         strap_take;

    // Taking the strap before the stages fill would latch the reset value.
    assign strap_take = !strap_done_q && strap_vld_q[`LPRT_SYNC_STAGES-1]
                        && (strap_s2_q == strap_s3_q);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_s1_q   <= 1'b0;
            strap_s2_q   <= 1'b0;
            strap_s3_q   <= 1'b0;
            strap_vld_q  <= '0;
            strap_q      <= 1'b0;
            strap_done_q <= 1'b0;
        end
        else
        begin
            strap_s1_q  <= delay_select;
            strap_s2_q  <= strap_s1_q;
            strap_s3_q  <= strap_s2_q;
            strap_vld_q <= {strap_vld_q[`LPRT_SYNC_STAGES-2:0], 1'b1};
            if (strap_take)
            begin
                strap_q      <= strap_s3_q;
                strap_done_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Delay selection
    // ----------------------------------------
    // Pulse builds ignore the strap and use their fixed delay.
    logic [TW-1:0] dly_target;
    logic [TW-1:0] rel_target;

    assign dly_target = !LATCHING ? TW'(DLY_FIXED) :
                        strap_q   ? TW'(DLY_HIGH)  : TW'(DLY_LOW);
    assign rel_target = TW'(REL_TICKS);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    lprt_state_t   state_q;
    lprt_state_t   state_d;
    logic [TW-1:0] cnt_q;
    logic [TW-1:0] cnt_d;
    logic          rst_d;
    logic          dly_done;
    logic          rel_done;

    // Counts are in whole ticks; the tick phase adds under one tick of
    // jitter, far inside the ten percent tolerance.
    assign dly_done = tick && (cnt_q == dly_target - 1'b1);
    assign rel_done = tick && (cnt_q == rel_target - 1'b1);

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rst_d   = 1'b0;
        case (state_q)
            LPRT_IDLE:
            begin
                cnt_d = '0;
                if (both_low)
                    state_d = LPRT_TIMING;
            end
            LPRT_TIMING:
            begin
                if (any_high)
                begin
                    state_d = LPRT_IDLE;
                    cnt_d   = '0;
                end
                else if (dly_done)
                begin
                    state_d = LPRT_ASSERT;
                    cnt_d   = '0;
                    rst_d   = 1'b1;
                end
                else if (tick)
                    cnt_d = cnt_q + 1'b1;
            end
            LPRT_ASSERT:
            begin
                rst_d = 1'b1;
                if (any_high)
                begin
                    state_d = LPRT_IDLE;
                    cnt_d   = '0;
                    rst_d   = 1'b0;
                end
                else if (!LATCHING && rel_done)
                begin
                    state_d = LPRT_WAIT_RISE;
                    cnt_d   = '0;
                    rst_d   = 1'b0;
                end
                else if (!LATCHING && tick)
                    cnt_d = cnt_q + 1'b1;
            end
            LPRT_WAIT_RISE:
            begin
                cnt_d = '0;
                if (any_high)
                    state_d = LPRT_IDLE;
            end
            default:
            begin
                state_d = LPRT_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= LPRT_IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ----------------------------------------
    // Output drivers
    // ----------------------------------------
    // All three outputs are one flop set; the enable and high output change on the same edge, and the data output stays low.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reset_out_n_o  <= 1'b0;
            reset_out_n_oe <= 1'b0;
            reset_out_high <= 1'b0;
        end
        else
        begin
            reset_out_n_o  <= 1'b0;
            reset_out_n_oe <= rst_d;
            reset_out_high <= rst_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_outputs_agree;
        @(posedge core_clk) disable iff (sys_rst)
        reset_out_high == reset_out_n_oe;
    endproperty
    a_outputs_agree: assert property (p_outputs_agree)
        else $error("High reset differs from open-drain reset.");

    property p_drive_low;
        @(posedge core_clk) disable iff (sys_rst)
        reset_out_n_oe |-> !reset_out_n_o;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("Open-drain reset driven high.");

    property p_assert_needs_keys;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(reset_out_n_oe)
            |-> $past(state_q) == LPRT_TIMING && $past(both_low);
    endproperty
    a_assert_needs_keys: assert property (p_assert_needs_keys)
        else $error("Reset asserted without a completed delay.");

    property p_full_delay;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(reset_out_n_oe) |-> $past(cnt_q) == dly_target - 1'b1;
    endproperty
    a_full_delay: assert property (p_full_delay)
        else $error("Reset asserted before the full delay.");

    property p_abandon;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == LPRT_TIMING && any_high) |=> state_q == LPRT_IDLE
            && !reset_out_n_oe;
    endproperty
    a_abandon: assert property (p_abandon)
        else $error("Timing not abandoned on key rise.");

    property p_release_on_rise;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == LPRT_ASSERT && any_high) |=> !reset_out_n_oe;
    endproperty
    a_release_on_rise: assert property (p_release_on_rise)
        else $error("Reset held after a key rose.");

    property p_pulse_length;
        @(posedge core_clk) disable iff (sys_rst)
        (!LATCHING && $fell(reset_out_n_oe) && $past(both_low))
            |-> $past(cnt_q) == rel_target - 1'b1;
    endproperty
    a_pulse_length: assert property (p_pulse_length)
        else $error("Pulse released at the wrong time.");

    property p_no_rearm;
        @(posedge core_clk) disable iff (sys_rst)
        state_q == LPRT_WAIT_RISE |=> !reset_out_n_oe;
    endproperty
    a_no_rearm: assert property (p_no_rearm)
        else $error("Reset reasserted without a key rise.");

    property p_latch_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (LATCHING && reset_out_n_oe && both_low) |=> reset_out_n_oe;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched reset dropped while keys held.");

    property p_wait_holds;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == LPRT_WAIT_RISE && both_low)
            |=> state_q == LPRT_WAIT_RISE;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("Pulse rearmed while keys stayed low.");

    c_assert: cover property (@(posedge core_clk) disable iff (sys_rst)
        $rose(reset_out_n_oe));
    c_abandon: cover property (@(posedge core_clk) disable iff (sys_rst)
        state_q == LPRT_TIMING && any_high);
    c_self_release: cover property (@(posedge core_clk) disable iff (sys_rst)
        state_q == LPRT_WAIT_RISE);

    initial
    begin
        if (DLY_LOW < 1 || DLY_HIGH < 1 || DLY_FIXED < 1 || REL_TICKS < 1)
            $error("Delay and release counts must be at least one.");
        if (DLY_HIGH >= (1 << TW) || DLY_FIXED >= (1 << TW))
            $error("Delay count exceeds counter width.");
    end
endmodule

/* verif/lprt_key_model.sv */
// Behavioural model of the two key switches and of the pulled-up reset wire.
// Assumes the bench sets the press wishes by non-blocking assignment.
`timescale 1ns/1ps
module lprt_key_model
(
    // Bench wishes
    input  wire logic       press_a,
    input  wire logic       press_b,
    input  wire logic       tie_b_low,
    // Open-drain reset of each timer
    input  wire logic [1:0] rst_o,
    input  wire logic [1:0] rst_oe,
    // Pins seen by the timers and by the system
    output logic            key_a_n,
    output logic            key_b_n,
    output logic [1:0]      rst_wire
);
    // ----------------------------------------
    // Keys
    // ----------------------------------------
    // An open switch leaves its pin on the pull-up.
    assign key_a_n = ~press_a;
    assign key_b_n = tie_b_low ? 1'b0 : ~press_b;

    // ----------------------------------------
    // Reset wire
    // ----------------------------------------
    // With no driver enabled the outside pull-up wins.
    assign rst_wire[0] = rst_oe[0] ? rst_o[0] : 1'b1;
    assign rst_wire[1] = rst_oe[1] ? rst_o[1] : 1'b1;
endmodule

/* verif/tb_top.sv */
// Self-checking bench: a latching and a pulse timer share the same keys.
// Assumes short tick and delay parameters so the run stays brief.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb_top;
    localparam int TICK  = 10;
    localparam int DLY_L = 5;
    localparam int DLY_H = 8;
    localparam int DLY_P = 3;
    localparam int REL   = 4;
    localparam int LIMIT = 20000;

    logic       core_clk;
    logic       sys_rst;
    logic       delay_select;
    logic       factory_gnd;
    logic       press_a;
    logic       press_b;
    logic       tie_b_low;
    logic       key_a_n;
    logic       key_b_n;
    logic [1:0] oe_v;
    logic [1:0] o_v;
    logic [1:0] hi_v;
    logic [1:0] wire_v;
    logic [1:0] prv;
    int         cyc;
    int         seed;
    int         miscompares;
    int         samples_checked;
    int         r_t[2];
    int         f_t[2];
    int         n_r[2];
    int         t0;
    int         t1;
    int         dl;

    // ----------------------------------------
    // Design and partner
    // ----------------------------------------
    // Factory pins are tied to ground and the strap is driven firmly.
    lprt_timer #(.LATCHING(1'b1), .TICK_CYC(TICK), .DLY_LOW(DLY_L),
        .DLY_HIGH(DLY_H), .DLY_FIXED(DLY_P), .REL_TICKS(REL)) i_lprt_timer
    (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .key_request_a_n(key_a_n), .key_request_b_n(key_b_n),
        .delay_select(delay_select),
        .factory_pin_a(factory_gnd), .factory_pin_b(factory_gnd),
        .reset_out_n_o(o_v[0]), .reset_out_n_oe(oe_v[0]),
        .reset_out_high(hi_v[0])
    );
    lprt_timer #(.LATCHING(1'b0), .TICK_CYC(TICK), .DLY_LOW(DLY_L),
        .DLY_HIGH(DLY_H), .DLY_FIXED(DLY_P), .REL_TICKS(REL))
        i_lprt_timer_pulse
    (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .key_request_a_n(key_a_n), .key_request_b_n(key_b_n),
        .delay_select(delay_select),
        .factory_pin_a(factory_gnd), .factory_pin_b(factory_gnd),
        .reset_out_n_o(o_v[1]), .reset_out_n_oe(oe_v[1]),
        .reset_out_high(hi_v[1])
    );
    lprt_key_model i_lprt_key_model
    (
        .press_a(press_a), .press_b(press_b), .tie_b_low(tie_b_low),
        .rst_o(o_v), .rst_oe(oe_v), .key_a_n(key_a_n),
        .key_b_n(key_b_n), .rst_wire(wire_v)
    );

    // ----------------------------------------
    // Clock, monitor and timeout
    // ----------------------------------------
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            miscompares++;
            final_report();
        end
    end

    // Edges are logged mid-cycle, where the outputs have settled.
    always @(negedge core_clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (oe_v[i] === 1'b1 && prv[i] !== 1'b1)
            begin
                r_t[i] = cyc;
                n_r[i]++;
            end
            if (oe_v[i] === 1'b0 && prv[i] === 1'b1)
                f_t[i] = cyc;
        end
        prv = oe_v;
        `CHK("high_out", oe_v, hi_v)
        `CHK("od_data", 2'b00, o_v)
        `CHK("od_wire", ~oe_v, wire_v)
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Whole-tick counting allows up to one tick of phase either way.
    function automatic bit in_win(input int d, input int n);
        return (d >= (n - 1) * TICK) && (d <= (n + 1) * TICK + 12);
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset(input logic st);
        @(posedge core_clk);
        sys_rst      <= 1'b1;
        delay_select <= st;
        repeat (5) @(posedge core_clk);
        `CHK("rst_oe", 2'b00, oe_v)
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        n_r = '{0, 0};
    endtask

    task automatic press(output int t);
        int sk;
        sk = $unsigned($random(seed)) % 6;
        @(posedge core_clk);
        press_a <= 1'b1;
        repeat (sk) @(posedge core_clk);
        press_b <= 1'b1;
        t = cyc;
    endtask

    task automatic rel_one(output int t);
        @(posedge core_clk);
        if ($random(seed) & 1)
            press_a <= 1'b0;
        else
            press_b <= 1'b0;
        t = cyc;
    endtask

    task automatic idle();
        @(posedge core_clk);
        press_a   <= 1'b0;
        press_b   <= 1'b0;
        tie_b_low <= 1'b0;
        repeat (20) @(posedge core_clk);
        n_r = '{0, 0};
    endtask

    task automatic wait_rise(input int i);
        int k;
        k = 0;
        while (oe_v[i] !== 1'b1 && k < 300)
        begin
            @(posedge core_clk);
            k++;
        end
    endtask

    task automatic full_cycle(input int d);
        press(t0);
        wait_rise(0);
        repeat (60) @(posedge core_clk);
        `CHK("lat_delay", 1'b1, in_win(r_t[0] - t0, d))
        `CHK("pls_delay", 1'b1, in_win(r_t[1] - t0, DLY_P))
        `CHK("pls_hold", 1'b1, in_win(f_t[1] - r_t[1], REL))
        `CHK("pls_count", 1, n_r[1])
        `CHK("lat_held", 2'b01, oe_v)
        rel_one(t1);
        repeat (10) @(posedge core_clk);
        `CHK("lat_fall", 1'b1, f_t[0] > t1 && f_t[0] - t1 <= 10)
        idle();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        delay_select = 1'b0;
        press_a = 1'b0;
        press_b = 1'b0;
        tie_b_low = 1'b0;
        factory_gnd = 1'b0;
        cyc = 0;
        seed = 42893;
        miscompares = 0;
        samples_checked = 0;
        prv = 2'b00;
        for (int s = 0; s < 2; s++)
        begin
            do_reset(s[0]);
            dl = s ? DLY_H : DLY_L;
            @(posedge core_clk);
            press_a <= 1'b1;
            repeat (120) @(posedge core_clk);
            `CHK("one_key", 0, n_r[0] + n_r[1])
            idle();
            press(t0);
            repeat (12) @(posedge core_clk);
            rel_one(t1);
            repeat (120) @(posedge core_clk);
            `CHK("abort", 0, n_r[0] + n_r[1])
            idle();
            repeat (2) full_cycle(dl);
        end
        // A key let go soon after the pulse starts cuts it short.
        press(t0);
        wait_rise(1);
        repeat (5) @(posedge core_clk);
        rel_one(t1);
        repeat (10) @(posedge core_clk);
        `CHK("early_rel", 1'b1, f_t[1] - r_t[1] <= 16)
        `CHK("early_oe", 2'b00, oe_v)
        idle();
        // One key used alone, the other held low for good.
        @(posedge core_clk);
        tie_b_low <= 1'b1;
        press_a   <= 1'b1;
        t0 = cyc;
        wait_rise(0);
        `CHK("single_key", 1'b1, in_win(r_t[0] - t0, DLY_H))
        idle();
        final_report();
    end
endmodule
